// ===== rtl/data_eeprom_access_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_map.vh"

// Operation
// - Fetch launch ignored without fetch permit
// - Read end clears launch, holds fetched byte
// - Page read increments offset after each byte
// - Offset saturates at 0FH, page bits fixed
// - Buffer cleared on reset and wipe permit fall
// - Page wipe: port write tags location, increments
// - Timed wipe clears launch; tagged bytes read zero
// - Wipe end drops wipe permit
// - Store launch ignored without store permit
// - Byte store erases byte first
// - Timed store end clears store launch
// - Buffer cleared on reset and store permit fall
// - Page store loads buffer; writes after 0FH dropped
// - Store end drops store permit
// - Completion event on wipe or store end
// - Store permit resets to zero
module data_eeprom_access_sequencer (
	input wire core_clk,
	input wire rst_b,
	input wire ctl_wr,
	input wire [6:0] ctl_wdata,
	input wire loc_wr,
	input wire [6:0] loc_wdata,
	input wire port_wr,
	input wire [7:0] port_wdata,
	output wire [6:0] nvm_control,
	output wire [6:0] nvm_location,
	output reg [7:0] nvm_byte_port,
	output reg done_event
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_FETCH = 2'b01;
	localparam [1:0] S_TIME = 2'b10;
	localparam [1:0] S_COMMIT = 2'b11;

	reg [1:0] state_reg;
	reg wipe_permit_reg, wipe_launch_reg, mode_reg, store_permit_reg;
	reg store_launch_reg, fetch_permit_reg, fetch_launch_reg;
	reg [2:0] page_reg;
	reg [3:0] ofs_reg;
	reg page_end_reg;
	reg op_store_reg, op_page_reg;
	reg [15:0] tick_cnt_reg;
	reg [7:0] div_reg;
	reg sub_tick_reg;
	reg [3:0] idx_reg;
	reg wipe_permit_d_reg, store_permit_d_reg;
	reg [7:0] buf_data [0:15];
	reg [15:0] buf_valid;

	wire busy = (state_reg != S_IDLE);
	wire [7:0] rd_data;
	wire buf_clear;
	wire buf_load;
	wire [15:0] dur;
	wire commit_last;
	reg arr_we;
	reg [6:0] arr_addr;
	reg [7:0] arr_wdata;

	assign nvm_control = {wipe_permit_reg, wipe_launch_reg, mode_reg, store_permit_reg,
		store_launch_reg, fetch_permit_reg, fetch_launch_reg};
	assign nvm_location = {page_reg, ofs_reg};

	// ----------------------------------------
	// Slow tick divider
	// ----------------------------------------
	// Stands in for the free-running subsidiary oscillator
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= 8'h00;
			sub_tick_reg <= 1'b0;
		end else if (div_reg == `SUB_DIV_LAST) begin
			div_reg <= 8'h00;
			sub_tick_reg <= 1'b1;
		end else begin
			div_reg <= div_reg + 8'h01;
			sub_tick_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Page buffer
	// ----------------------------------------
	assign buf_clear = (wipe_permit_d_reg & ~wipe_permit_reg) |
		(store_permit_d_reg & ~store_permit_reg);
	assign buf_load = port_wr & mode_reg & ~busy & ~page_end_reg;

	genvar g;
	generate
		for (g = 0; g < `PAGE_BYTES; g = g + 1) begin : g_buf
			always @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					buf_data[g] <= `BYTE_RESET;
					buf_valid[g] <= 1'b0;
				end else if (buf_clear) begin
					buf_data[g] <= `BYTE_RESET;
					buf_valid[g] <= 1'b0;
				end else if (buf_load && ofs_reg == g) begin
					buf_data[g] <= port_wdata;
					buf_valid[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Array port
	// ----------------------------------------
	assign commit_last = op_page_reg ? (idx_reg == `OFS_LAST) : (idx_reg == 4'h1);
	assign dur = op_store_reg ? `STORE_TICKS : `WIPE_TICKS;

	always @* begin
		arr_we = 1'b0;
		arr_addr = {page_reg, ofs_reg};
		arr_wdata = `ERASED_BYTE;
		if (state_reg == S_COMMIT) begin
			if (op_page_reg) begin
				arr_addr = {page_reg, idx_reg};
				arr_we = buf_valid[idx_reg];
				arr_wdata = op_store_reg ? buf_data[idx_reg] : `ERASED_BYTE;
			end else begin
				arr_we = 1'b1;
				// Byte erase on the first step, then the data
				arr_wdata = (idx_reg == 4'h0) ? `ERASED_BYTE : nvm_byte_port;
			end
		end
	end

	nvm_array i_nvm_array (
		.core_clk(core_clk),
		.wr_en(arr_we),
		.addr(arr_addr),
		.wr_data(arr_wdata),
		.rd_data(rd_data)
	);

	// ----------------------------------------
	// Control, location and sequencing
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_IDLE;
			wipe_permit_reg <= 1'b0;
			wipe_launch_reg <= 1'b0;
			mode_reg <= 1'b0;
			store_permit_reg <= 1'b0;
			store_launch_reg <= 1'b0;
			fetch_permit_reg <= 1'b0;
			fetch_launch_reg <= 1'b0;
			wipe_permit_d_reg <= 1'b0;
			store_permit_d_reg <= 1'b0;
			page_reg <= 3'h0;
			ofs_reg <= 4'h0;
			page_end_reg <= 1'b0;
			op_store_reg <= 1'b0;
			op_page_reg <= 1'b0;
			tick_cnt_reg <= 16'h0000;
			idx_reg <= 4'h0;
			nvm_byte_port <= `BYTE_RESET;
			done_event <= 1'b0;
		end else begin
			wipe_permit_d_reg <= wipe_permit_reg;
			store_permit_d_reg <= store_permit_reg;
			done_event <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (ctl_wr) begin
						wipe_permit_reg <= ctl_wdata[`CTL_WIPE_PERMIT];
						mode_reg <= ctl_wdata[`CTL_MODE];
						store_permit_reg <= ctl_wdata[`CTL_STORE_PERMIT];
						fetch_permit_reg <= ctl_wdata[`CTL_FETCH_PERMIT];
						// Launch honoured only if permit already stood
						tick_cnt_reg <= 16'h0000;
						idx_reg <= 4'h0;
						op_page_reg <= mode_reg;
						if (ctl_wdata[`CTL_WIPE_LAUNCH] && wipe_permit_reg && mode_reg) begin
							wipe_launch_reg <= 1'b1;
							op_store_reg <= 1'b0;
							state_reg <= S_TIME;
						end else if (ctl_wdata[`CTL_STORE_LAUNCH] && store_permit_reg) begin
							store_launch_reg <= 1'b1;
							op_store_reg <= 1'b1;
							state_reg <= S_TIME;
						end else if (ctl_wdata[`CTL_FETCH_LAUNCH] && fetch_permit_reg) begin
							fetch_launch_reg <= 1'b1;
							state_reg <= S_FETCH;
						end
					end
					if (loc_wr) begin
						page_reg <= loc_wdata[6:4];
						ofs_reg <= loc_wdata[3:0];
						page_end_reg <= 1'b0;
					end else if (port_wr) begin
						if (!mode_reg || !page_end_reg) begin
							nvm_byte_port <= port_wdata;
						end
						if (buf_load) begin
							if (ofs_reg == `OFS_LAST) begin
								page_end_reg <= 1'b1;
							end else begin
								ofs_reg <= ofs_reg + 4'h1;
							end
						end
					end
				end
				S_FETCH: begin
					if (sub_tick_reg) begin
						tick_cnt_reg <= tick_cnt_reg + 16'h0001;
					end
					if (tick_cnt_reg == `FETCH_TICKS) begin
						// Address has been steady for many cycles, so rd_data is settled
						nvm_byte_port <= rd_data;
						fetch_launch_reg <= 1'b0;
						if (mode_reg && ofs_reg != `OFS_LAST) begin
							ofs_reg <= ofs_reg + 4'h1;
						end
						state_reg <= S_IDLE;
					end
				end
				S_TIME: begin
					if (sub_tick_reg) begin
						tick_cnt_reg <= tick_cnt_reg + 16'h0001;
					end
					if (tick_cnt_reg == dur) begin
						state_reg <= S_COMMIT;
					end
				end
				S_COMMIT: begin
					idx_reg <= idx_reg + 4'h1;
					if (commit_last) begin
						done_event <= 1'b1;
						if (op_store_reg) begin
							store_launch_reg <= 1'b0;
							store_permit_reg <= 1'b0;
						end else begin
							wipe_launch_reg <= 1'b0;
							wipe_permit_reg <= 1'b0;
						end
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

endmodule // data_eeprom_access_sequencer

`default_nettype wire

// ===== rtl/nvm_access_map.vh
`ifndef NVM_ACCESS_MAP_VH
`define NVM_ACCESS_MAP_VH

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define CTL_WIPE_PERMIT 6
`define CTL_WIPE_LAUNCH 5
`define CTL_MODE 4
`define CTL_STORE_PERMIT 3
`define CTL_STORE_LAUNCH 2
`define CTL_FETCH_PERMIT 1
`define CTL_FETCH_LAUNCH 0
`define CTL_WIDTH 7
`define CTL_RESET 7'h00

// ----------------------------------------
// Location layout
// ----------------------------------------
`define LOC_WIDTH 7
`define LOC_RESET 7'h00
`define OFS_WIDTH 4
`define OFS_LAST 4'hf
`define PAGE_BYTES 16
`define BYTE_RESET 8'h00
`define ERASED_BYTE 8'h00

// ----------------------------------------
// Internal timer, counted in slow ticks
// ----------------------------------------
`define SUB_DIV_LAST 8'h05
`define FETCH_TICKS 16'h0002
`define WIPE_TICKS 16'h0010
`define STORE_TICKS 16'h0010

`endif

// ===== rtl/nvm_array.v
`timescale 1ns/1ps
`default_nettype none

module nvm_array (
	input wire core_clk,
	input wire wr_en,
	input wire [6:0] addr,
	input wire [7:0] wr_data,
	output reg [7:0] rd_data
);

	reg [7:0] cells [0:127];

	// Registered read; a write returns the old contents that cycle
	always @(posedge core_clk) begin
		if (wr_en) begin
			cells[addr] <= wr_data;
		end
		rd_data <= cells[addr];
	end

endmodule // nvm_array

`default_nettype wire

// ===== tb/nvm_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_seq_checker (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ctl_wr,
	input wire logic [6:0] ctl_wdata,
	input wire logic loc_wr,
	input wire logic port_wr,
	input wire logic [6:0] nvm_control,
	input wire logic [6:0] nvm_location,
	input wire logic [7:0] nvm_byte_port,
	input wire logic done_event
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire idle = !nvm_control[5] && !nvm_control[2] && !nvm_control[0];
	sequence store_end; $fell(nvm_control[2]); endsequence
	sequence wipe_end; $fell(nvm_control[5]); endsequence
	fetch_gate_a: assert property (ctl_wr && idle && !nvm_control[1] |=> !nvm_control[0])
		else $error("fetch ran without permit");
	fetch_take_a: assert property (
		ctl_wr && idle && nvm_control[1] && ctl_wdata[1:0] == 2'h3
		&& !ctl_wdata[5] && !ctl_wdata[2] |=> nvm_control[0])
		else $error("fetch not started");
	store_gate_a: assert property (ctl_wr && idle && !nvm_control[3] |=> !nvm_control[2])
		else $error("store ran without permit");
	store_end_a: assert property (store_end |-> done_event && !nvm_control[3])
		else $error("store end wrong");
	wipe_end_a: assert property (wipe_end |-> done_event && !nvm_control[6])
		else $error("wipe end wrong");
	event_pulse_a: assert property (done_event |=> !done_event)
		else $error("event too long");
	store_bound_a: assert property (
		$rose(nvm_control[2]) |-> ##[1:400] !nvm_control[2])
		else $error("store hangs");
	page_fixed_a: assert property (!loc_wr |=> $stable(nvm_location[6:4]))
		else $error("page bits moved");
	offset_sat_a: assert property (
		nvm_location[3:0] == 4'hf && !loc_wr |=> nvm_location[3:0] == 4'hf)
		else $error("offset wrapped");
	port_hold_a: assert property (
		$changed(nvm_byte_port) |-> $past(port_wr) || $fell(nvm_control[0]))
		else $error("byte port changed");
endmodule // nvm_seq_checker
bind data_eeprom_access_sequencer nvm_seq_checker i_nvm_seq_checker (.core_clk, .rst_b, .ctl_wr,
	.ctl_wdata, .loc_wr, .port_wr, .nvm_control, .nvm_location, .nvm_byte_port, .done_event);
`default_nettype wire

// ===== tb/test_data_eeprom_access_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_access_sequencer;
	logic core_clk = 0;
	logic rst_b = 0;
	logic ctl_wr = 0;
	logic loc_wr = 0;
	logic port_wr = 0;
	logic [6:0] ctl_wdata = 7'h00;
	logic [6:0] loc_wdata = 7'h00;
	logic [7:0] port_wdata = 8'h00;
	wire [6:0] nvm_control;
	wire [6:0] nvm_location;
	wire [7:0] nvm_byte_port;
	wire done_event;
	int errors = 0;
	int checks = 0;
	data_eeprom_access_sequencer i_data_eeprom_access_sequencer (.core_clk, .rst_b, .ctl_wr,
		.ctl_wdata, .loc_wr, .loc_wdata, .port_wr, .port_wdata, .nvm_control, .nvm_location,
		.nvm_byte_port, .done_event);
	initial forever #2.5 core_clk = ~core_clk;
	// ----------
	// Access tasks
	// ----------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		#1;
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Kind 0 control, 1 location, 2 byte port
	task automatic wr(input int k, input logic [7:0] v);
		@(posedge core_clk);
		ctl_wr <= k == 0;
		loc_wr <= k == 1;
		port_wr <= k == 2;
		ctl_wdata <= v[6:0];
		loc_wdata <= v[6:0];
		port_wdata <= v;
		@(posedge core_clk);
		ctl_wr <= 0;
		loc_wr <= 0;
		port_wr <= 0;
		// Step off the edge so later samples see settled outputs
		#1;
	endtask
	// Bounded poll; a stuck bit shows in the next compare
	task automatic wt(input int b);
		repeat (500) begin
			@(posedge core_clk);
			#1;
			if (nvm_control[b] === 1'b0) break;
		end
	endtask
	task automatic rd(input int n, input int z);
		wr(1, 8'h20);
		wr(0, 8'h12);
		for (int i = 0; i < n; i++) begin
			wr(0, 8'h13);
			wt(0);
			chk(nvm_byte_port, i < z ? 8'h00 : 8'((i > 15 ? 15 : i) * 3 + 1));
			chk({1'b0, nvm_location}, 8'(32 + (i < 15 ? i + 1 : 15)));
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------
	// Tests
	// ----------
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1;
		wr(1, 8'h12);
		wr(2, 8'ha5);
		// Divider runs from reset, so the slow tick is steady here
		wr(0, 8'h08);
		wr(0, 8'h0c);
		wt(2);
		chk({1'b0, nvm_control}, 8'h00);
		wr(2, 8'h5a);
		wr(0, 8'h02);
		wr(0, 8'h03);
		wt(0);
		chk(nvm_byte_port, 8'ha5);
		chk({1'b0, nvm_control}, 8'h02);
		$display("byte store and read done");
		wr(0, 8'h00);
		wr(0, 8'h01);
		chk({1'b0, nvm_control}, 8'h00);
		wr(0, 8'h04);
		chk({1'b0, nvm_control}, 8'h00);
		$display("launch refusal done");
		wr(0, 8'h10);
		wr(1, 8'h20);
		repeat (16) wr(2, 8'h00);
		wr(0, 8'h50);
		wr(0, 8'h70);
		wt(5);
		chk({1'b0, nvm_control}, 8'h10);
		wr(1, 8'h20);
		for (int i = 0; i < 17; i++) wr(2, 8'(i * 3 + 1));
		chk({1'b0, nvm_location}, 8'h2f);
		wr(0, 8'h18);
		wr(0, 8'h1c);
		wt(2);
		chk({1'b0, nvm_control}, 8'h10);
		rd(17, 0);
		$display("page erase write read done");
		// Partial wipe, then a store whose buffer was dropped
		wr(1, 8'h20);
		repeat (4) wr(2, 8'h00);
		wr(0, 8'h50);
		wr(0, 8'h70);
		wt(5);
		wr(0, 8'h18);
		wr(1, 8'h24);
		wr(2, 8'hff);
		wr(0, 8'h10);
		wr(0, 8'h18);
		wr(0, 8'h1c);
		wt(2);
		rd(5, 4);
		wr(0, 8'h50);
		wr(1, 8'h24);
		wr(2, 8'h00);
		wr(0, 8'h10);
		wr(0, 8'h50);
		wr(0, 8'h70);
		wt(5);
		rd(5, 4);
		$display("buffer clear done");
		report_and_stop();
	end
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end
endmodule // test_data_eeprom_access_sequencer
`default_nettype wire
